// >>> pvi_top.sv
// Private VLAN port isolation: APB registers, ingress classification
// and egress port set per frame.
// Assumes one clock, synchronous inputs and an APB3 master.
// Frame descriptors may come every cycle; each answer follows one cycle later.
// Isolation and VLAN table writes act at once; private VLAN edits wait for
// a commit, so a half-edited table never steers a frame.
`timescale 1ns/10ps
module pvi_top (
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      rstn,
  // APB slave
  input  wire logic [pvi_pkg::AW-1:0]    paddr,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Ingress frame descriptor
  input  wire logic                      in_valid,
  input  wire logic [pvi_pkg::PW-1:0]    in_port,
  input  wire logic                      in_tagged,
  input  wire logic [pvi_pkg::VIDW-1:0]  in_vid,
  // Egress decision
  output logic                           eg_valid,
  output logic      [pvi_pkg::NPORT-1:0] eg_mask,
  output logic      [pvi_pkg::NPORT-1:0] eg_strip,
  output logic      [pvi_pkg::VIDW-1:0]  eg_vid
);
  import pvi_pkg::*;

  // State of this module, apart from the VLAN table and egress stage; one comb process fills next_st, one flop stage holds it
  typedef struct packed {
    // Bus answer
    logic                       rdy;                // Access phase answered
    logic                       err;                // Answer is an error
    logic [31:0]                rdata;              // Read data held for answer
    // Port configuration
    logic [NPORT-1:0]           isolate;            // Isolation enables
    logic [NPORT-1:0][VIDW-1:0] port_default_vlan_id; // Port default VLAN ids
    // Private VLAN table, staged and active copies
    logic [NPV-1:0]             st_valid;           // Staged entry exists
    logic [NPV-1:0][NPORT-1:0]  st_mask;            // Staged member masks
    logic [NPV-1:0]             ac_valid;           // Active entry exists
    logic [NPV-1:0][NPORT-1:0]  ac_mask;            // Active member masks
    // Status
    logic                       bad_id;             // Sticky rejected id
  } pvi_st_t;

  // State register and its next value
  pvi_st_t st;                                      // Registered state
  pvi_st_t next_st;                                 // Next state

  // Address decode, used for the answer and for the write
  // Any unaligned or unmapped address gives K_NONE
  function automatic pvi_kind_t pvi_decode(input logic [AW-1:0] a);
    pvi_decode = K_NONE;
    // Unaligned words never match, so they answer with an error
    if (a[1:0] == 2'b00) begin
      // Fixed control words first
      if (a == OFS_CTRL) begin
        pvi_decode = K_CTRL;
      end else if (a == OFS_ISOL) begin
        pvi_decode = K_ISOL;
      end else if (a == OFS_PVCMD) begin
        pvi_decode = K_PVCMD;
      end else if (a == OFS_STAT) begin
        pvi_decode = K_STAT;
      end else if (a[AW-1:5] == DEFVLAN_PAGE) begin
        // Paged registers, one word per port or table entry
        pvi_decode = K_DEFVLAN;
      end else if (a[AW-1:6] == VLAN_PAGE) begin
        pvi_decode = K_VLAN;
      end else if (a[AW-1:5] == PV_PAGE) begin
        pvi_decode = K_PV;
      end
    end
  endfunction

  // Bus side helpers
  pvi_kind_t       kind;                            // Decoded register kind
  logic            wr_fire;                         // Write takes effect now
  logic            vt_wr;                           // VLAN table write strobe
  logic [15:0]     vt_rd;                           // VLAN table read data
  logic [VIDW-1:0] cls_vid;                         // Classified VLAN of frame
  pvi_ports_t      vt_member;                       // Members of that VLAN
  pvi_ports_t      vt_untag;                        // Untagged members of it
  // Fields of a private VLAN add or delete command
  logic [3:0]      cmd_id;                          // Private VLAN id of command
  logic [PW-1:0]   cmd_ix;                          // Table slot of that id
  logic            cmd_ok;                          // Id within port range

  // Decode once; the answer and the write both use it
  assign kind    = pvi_decode(paddr);
  // Writes land only at the completing edge, and never on an error answer
  assign wr_fire = psel && penable && st.rdy && pwrite && !st.err;
  assign vt_wr   = wr_fire && (kind == K_VLAN);
  // Id in the low nibble; slot 0 holds private VLAN 1
  assign cmd_id  = pwdata[3:0];
  assign cmd_ix  = PW'(cmd_id - PV_ID_MIN);
  assign cmd_ok  = (cmd_id >= PV_ID_MIN) && (cmd_id <= PV_ID_MAX);

  // Ingress classification
  // The tag wins; an untagged frame falls back to its port's default id
  assign cls_vid = in_tagged ? in_vid : st.port_default_vlan_id[in_port];

  // VLAN membership table
  // Bus reads and writes share one word index; frame lookups use the class id
  pvi_vlan_tab u_vlan_tab (
    .mclk      (mclk),
    .rstn      (rstn),
    .wr_en     (vt_wr),
    .wr_idx    (paddr[VIXW+1:2]),
    .wr_data   (pwdata[15:0]),
    .rd_idx    (paddr[VIXW+1:2]),
    .rd_data   (vt_rd),
    .lk_vid    (cls_vid),
    .lk_member (vt_member),
    .lk_untag  (vt_untag)
  );

  // Egress set stage, fed from committed private VLAN tables and the live VLAN table
  // Isolation enables act at once; masks change only at a commit
  pvi_egress u_egress (
    .mclk        (mclk),
    .rstn        (rstn),
    .in_valid    (in_valid),
    .in_port     (in_port),
    .in_vid      (cls_vid),
    .vlan_member (vt_member),
    .vlan_untag  (vt_untag),
    .isolate     (st.isolate),
    .pv_valid    (st.ac_valid),
    .pv_masks    (st.ac_mask),
    .eg_valid    (eg_valid),
    .eg_mask     (eg_mask),
    .eg_strip    (eg_strip),
    .eg_vid      (eg_vid)
  );

  // Register file and APB answer
  // One wait state: the first access edge latches the answer, the next ends it
  always_comb begin
    logic [PW-1:0] ix;                              // Word index in a page
    ix = paddr[PW+1:2];
    next_st = st;
    // First access cycle: latch answer; second: complete
    if (psel && penable && !st.rdy) begin
      // Latched answer keeps prdata a flop output, held until the next access
      next_st.rdy   = 1'b1;
      next_st.err   = (kind == K_NONE);
      next_st.rdata = '0;
      unique case (kind)
        K_CTRL: begin
          next_st.rdata = '0;                       // Commit is write-only
        end
        K_ISOL: begin
          // Isolation enables in the low byte
          next_st.rdata[NPORT-1:0] = st.isolate;
        end
        K_PVCMD: begin
          // Command word is write-only
          next_st.rdata = '0;
        end
        K_STAT: begin
          // Sticky rejected-id flag
          next_st.rdata[STAT_BADID] = st.bad_id;
        end
        K_DEFVLAN: begin
          // Default id of one port
          next_st.rdata[VIDW-1:0] = st.port_default_vlan_id[ix];
        end
        K_VLAN: begin
          // Members in the low byte, untagged members above
          next_st.rdata[15:0] = vt_rd;
        end
        K_PV: begin
          // Staged and active views side by side
          next_st.rdata[NPORT-1:0]   = st.st_mask[ix];
          next_st.rdata[2*NPORT-1:NPORT] = st.ac_mask[ix];
          next_st.rdata[PV_STVALID]  = st.st_valid[ix];
          next_st.rdata[PV_ACVALID]  = st.ac_valid[ix];
        end
        K_NONE: begin
          next_st.rdata = '0;                       // Unmapped reads as zero
        end
      endcase
    end else begin
      // Idle, setup or answered: the answer lasts one cycle only
      next_st.rdy = 1'b0;
      next_st.err = 1'b0;
    end
    // Write effects at the completing edge
    // Errors never get here: wr_fire already leaves them out
    if (wr_fire) begin
      unique case (kind)
        K_CTRL: begin
          // Staged private VLANs go live together
          if (pwdata[CTRL_COMMIT]) begin
            // Frames in flight use the old table up to this edge
            next_st.ac_valid = st.st_valid;
            next_st.ac_mask  = st.st_mask;
          end
        end
        K_ISOL: begin
          // Steers the very next frame already
          next_st.isolate = pwdata[NPORT-1:0];
        end
        K_PVCMD: begin
          // Add wins when both bits are set
          if (pwdata[PVCMD_ADD] || pwdata[PVCMD_DEL]) begin
            if (!cmd_ok) begin
              // Rejected ids leave both tables untouched
              next_st.bad_id = 1'b1;
            end else if (pwdata[PVCMD_ADD]) begin
              next_st.st_valid[cmd_ix] = 1'b1;
              next_st.st_mask[cmd_ix]  = NO_PORTS;
            end else begin
              // Delete clears the mask too, so a later add starts empty
              next_st.st_valid[cmd_ix] = 1'b0;
              next_st.st_mask[cmd_ix]  = NO_PORTS;
            end
          end
        end
        K_STAT: begin
          // Write one clears; only a command sets it, so no race
          if (pwdata[STAT_BADID]) begin
            next_st.bad_id = 1'b0;
          end
        end
        K_DEFVLAN: begin
          // Used for untagged frames from the next cycle on
          next_st.port_default_vlan_id[ix] = pwdata[VIDW-1:0];
        end
        K_VLAN: begin
          next_st.rdy = 1'b0;                       // Stored in the table module
        end
        K_PV: begin
          // Membership edits need an existing staged entry
          if (st.st_valid[ix]) begin
            next_st.st_mask[ix] = pwdata[NPORT-1:0];
          end
        end
        K_NONE: begin
          // Unreachable: an error answer never writes
          next_st.rdy = 1'b0;
        end
      endcase
    end
    // Reset: no isolation, every port in private VLAN 1
    // Reset comes last so it wins over a bus write in the same cycle
    if (!rstn) begin
      next_st          = '0;
      next_st.isolate  = NO_PORTS;
      // Every port starts on VLAN 1; the VLAN table resets itself
      for (int p = 0; p < NPORT; p++) begin
        next_st.port_default_vlan_id[p] = DEFVLAN_RST;
      end
      next_st.st_valid[0] = 1'b1;
      next_st.st_mask[0]  = ALL_PORTS;
      next_st.ac_valid[0] = 1'b1;
      next_st.ac_mask[0]  = ALL_PORTS;
    end
  end

  // Single state register
  // Reset is folded into next_st, so the flops need no reset branch
  always_ff @(posedge mclk) begin
    st <= next_st;
  end

  // Bus outputs straight from state flops
  // No logic between flop and pin keeps the bus timing simple
  assign prdata  = st.rdata;
  assign pready  = st.rdy;
  assign pslverr = st.err;

endmodule

// >>> pvi_pkg.sv
// Shared constants and types of the private VLAN port isolation block.
// Assumes an eight port switch with one clock and APB register access.
package pvi_pkg;

  // Sizes
  localparam int NPORT = 8;                         // Switch ports
  localparam int PW    = 3;                         // Port number width
  localparam int VIDW  = 12;                        // VLAN identifier width
  localparam int NVLAN = 16;                        // VLAN table entries
  localparam int VIXW  = 4;                         // VLAN table index width
  localparam int NPV   = 8;                         // Private VLANs, ids 1..NPORT
  localparam int AW    = 12;                        // APB address width

  // Register byte offsets
  localparam logic [AW-1:0] OFS_CTRL  = 12'h000;    // Commit staged private VLANs
  localparam logic [AW-1:0] OFS_ISOL  = 12'h004;    // Per-port isolation enables
  localparam logic [AW-1:0] OFS_PVCMD = 12'h008;    // Add or delete a private VLAN
  localparam logic [AW-1:0] OFS_STAT  = 12'h00C;    // Sticky rejected-id flag
  localparam logic [6:0]    DEFVLAN_PAGE = 7'h02;   // 0x040..0x05C, paddr[11:5]
  localparam logic [5:0]    VLAN_PAGE = 6'h02;      // 0x080..0x0BC, paddr[11:6]
  localparam logic [6:0]    PV_PAGE   = 7'h06;      // 0x0C0..0x0DC, paddr[11:5]

  // Field positions
  localparam int CTRL_COMMIT = 0;                   // Write one to commit
  localparam int PVCMD_ADD   = 8;                   // Create entry, empty mask
  localparam int PVCMD_DEL   = 9;                   // Remove entry
  localparam int STAT_BADID  = 0;                   // Rejected identifier seen
  localparam int PV_STVALID  = 16;                  // Staged entry exists
  localparam int PV_ACVALID  = 17;                  // Active entry exists
  localparam int VLAN_UNTAG  = 8;                   // Untag mask at [15:8]

  // Reset values
  localparam logic [VIDW-1:0]  DEFVLAN_RST = 12'h001; // Every port defaults to VLAN 1
  localparam logic [VIXW-1:0]  VLAN_DEF   = 4'h1;     // Default VLAN entry
  localparam logic [NPORT-1:0] ALL_PORTS  = 8'hFF;
  localparam logic [NPORT-1:0] NO_PORTS   = 8'h00;
  localparam logic [3:0]       PV_ID_MIN  = 4'h1;
  localparam logic [3:0]       PV_ID_MAX  = 4'h8;

  // Register kinds from address decode
  typedef enum logic [2:0] {
    K_CTRL  = 3'b000,
    K_ISOL  = 3'b001,
    K_PVCMD = 3'b010,
    K_STAT  = 3'b011,
    K_DEFVLAN = 3'b100,
    K_VLAN  = 3'b101,
    K_PV    = 3'b110,
    K_NONE  = 3'b111
  } pvi_kind_t;

  typedef logic [NPORT-1:0] pvi_ports_t;

  // One-hot port set of a port number
  function automatic pvi_ports_t pvi_onehot(input logic [PW-1:0] p);
    pvi_onehot = pvi_ports_t'(1) << p;
  endfunction

endpackage

// >>> pvi_vlan_tab.sv
// VLAN membership and untag table, one entry per supported VLAN id.
// Assumes writes come from the APB slave and lookups are combinational.
`timescale 1ns/10ps
module pvi_vlan_tab (
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      rstn,
  // Software write port
  input  wire logic                      wr_en,
  input  wire logic [pvi_pkg::VIXW-1:0]  wr_idx,
  input  wire logic [15:0]               wr_data,
  // Software read port
  input  wire logic [pvi_pkg::VIXW-1:0]  rd_idx,
  output logic      [15:0]               rd_data,
  // Frame lookup
  input  wire logic [pvi_pkg::VIDW-1:0]  lk_vid,
  output logic      [pvi_pkg::NPORT-1:0] lk_member,
  output logic      [pvi_pkg::NPORT-1:0] lk_untag
);
  import pvi_pkg::*;

  typedef struct packed {
    logic [NVLAN-1:0][15:0] tab;                    // {untag, member} per VLAN
  } pvi_vt_t;

  pvi_vt_t st;                                      // Registered table
  pvi_vt_t next_st;                                 // Next table

  // Reset puts every port in VLAN 1, untagged
  always_comb begin
    next_st = st;
    if (!rstn) begin
      next_st.tab = '0;
      next_st.tab[VLAN_DEF] = {ALL_PORTS, ALL_PORTS};
    end else if (wr_en) begin
      next_st.tab[wr_idx] = wr_data;
    end
  end

  always_ff @(posedge mclk) begin
    st <= next_st;
  end

  // Lookup; ids beyond the table have no members at all
  always_comb begin
    rd_data   = st.tab[rd_idx];
    lk_member = NO_PORTS;
    lk_untag  = NO_PORTS;
    if (lk_vid < VIDW'(NVLAN)) begin
      lk_member = st.tab[lk_vid[VIXW-1:0]][NPORT-1:0];
      lk_untag  = st.tab[lk_vid[VIXW-1:0]][VLAN_UNTAG +: NPORT];
    end
  end

endmodule

// >>> pvi_egress.sv
// Egress port set calculation, one registered stage.
// Assumes tables are stable in the cycle a frame is presented.
`timescale 1ns/10ps
module pvi_egress (
  // Clock and reset
  input  wire logic                              mclk,
  input  wire logic                              rstn,
  // Classified frame
  input  wire logic                              in_valid,
  input  wire logic [pvi_pkg::PW-1:0]            in_port,
  input  wire logic [pvi_pkg::VIDW-1:0]          in_vid,
  input  wire logic [pvi_pkg::NPORT-1:0]         vlan_member,
  input  wire logic [pvi_pkg::NPORT-1:0]         vlan_untag,
  // Active configuration
  input  wire logic [pvi_pkg::NPORT-1:0]         isolate,
  input  wire logic [pvi_pkg::NPV-1:0]           pv_valid,
  input  wire logic [pvi_pkg::NPV*pvi_pkg::NPORT-1:0] pv_masks,
  // Result
  output logic                                   eg_valid,
  output logic      [pvi_pkg::NPORT-1:0]         eg_mask,
  output logic      [pvi_pkg::NPORT-1:0]         eg_strip,
  output logic      [pvi_pkg::VIDW-1:0]          eg_vid
);
  import pvi_pkg::*;

  typedef struct packed {
    logic             valid;
    logic [NPORT-1:0] mask;
    logic [NPORT-1:0] strip;
    logic [VIDW-1:0]  vid;
  } pvi_eg_t;

  pvi_eg_t st;                                      // Output stage
  pvi_eg_t next_st;                                 // Next output stage

  // Set calculation; the private VLAN masks are keyed by source port only
  always_comb begin
    pvi_ports_t src;                                // Ingress port as a set
    pvi_ports_t prom;                               // Reachable promiscuous ports
    pvi_ports_t m;                                  // Working egress set
    logic       in_pv;                              // Source in an active pvlan
    src   = pvi_onehot(in_port);
    prom  = NO_PORTS;
    m     = NO_PORTS;
    in_pv = 1'b0;
    next_st = st;
    // Union over private VLANs that hold the source
    for (int i = 0; i < NPV; i++) begin
      if (pv_valid[i] && pv_masks[i*NPORT + int'(in_port)]) begin
        in_pv = 1'b1;
        prom  = prom | (pv_masks[i*NPORT +: NPORT] & ~isolate);
      end
    end
    // Source needs both memberships to forward
    if (in_pv && ((vlan_member & src) != NO_PORTS)) begin
      if (isolate[in_port]) begin
        m = vlan_member & prom;
      end else begin
        m = vlan_member;
      end
    end
    m = m & vlan_member & ~pvi_onehot(in_port);
    next_st.valid = in_valid;
    if (in_valid) begin
      next_st.mask  = m;
      next_st.strip = m & vlan_untag;
      next_st.vid   = in_vid;
    end
    if (!rstn) begin
      next_st = '0;
    end
  end

  // Fixed one-cycle latency
  always_ff @(posedge mclk) begin
    st <= next_st;
  end

  assign eg_valid = st.valid;
  assign eg_mask  = st.mask;
  assign eg_strip = st.strip;
  assign eg_vid   = st.vid;

endmodule

// >>> pvi_top_chk_props.sv
// Port checks for the private VLAN isolation block.
// Assumes one clock domain and rstn synchronous, active low.
`timescale 1ns/10ps
module pvi_top_chk (
  // Clock and reset
  input wire logic                      mclk,
  input wire logic                      rstn,
  // Ingress descriptor
  input wire logic                      in_valid,
  input wire logic [pvi_pkg::PW-1:0]    in_port,
  input wire logic                      in_tagged,
  input wire logic [pvi_pkg::VIDW-1:0]  in_vid,
  // Egress decision
  input wire logic                      eg_valid,
  input wire logic [pvi_pkg::NPORT-1:0] eg_mask,
  input wire logic [pvi_pkg::NPORT-1:0] eg_strip,
  input wire logic [pvi_pkg::VIDW-1:0]  eg_vid
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // Answer exactly one cycle after the descriptor
  property p_eg_lat;
    in_valid |=> eg_valid;
  endproperty
  a_eg_lat: assert property (p_eg_lat) else $error("egress answer missing");

  // No answer without a descriptor
  property p_eg_only;
    !in_valid |=> !eg_valid;
  endproperty
  a_eg_only: assert property (p_eg_only) else $error("spurious egress answer");

  // Ingress port never appears in its own egress set
  property p_no_reflect;
    in_valid |=> eg_mask[$past(in_port)] == 1'b0;
  endproperty
  a_no_reflect: assert property (p_no_reflect) else $error("frame reflected");

  // Stripping only on ports that get a copy
  property p_strip_sub;
    eg_valid |-> (eg_strip & ~eg_mask) == 8'h00;
  endproperty
  a_strip_sub: assert property (p_strip_sub) else $error("strip outside mask");

  // Tagged frame keeps the id of its tag
  property p_tag_vid;
    in_valid && in_tagged |=> eg_vid == $past(in_vid);
  endproperty
  a_tag_vid: assert property (p_tag_vid) else $error("tagged id changed");

  // Ids beyond the table have no members
  property p_big_vid;
    in_valid && in_tagged && in_vid >= 12'h010 |=> eg_mask == 8'h00;
  endproperty
  a_big_vid: assert property (p_big_vid) else $error("copy for empty vlan");

  // Same case: nothing to strip either
  property p_big_strip;
    in_valid && in_tagged && in_vid >= 12'h010 |=> eg_strip == 8'h00;
  endproperty
  a_big_strip: assert property (p_big_strip) else $error("strip for empty vlan");

  // Mask and id hold between answers
  property p_hold;
    !eg_valid |-> $stable(eg_mask) && $stable(eg_vid);
  endproperty
  a_hold: assert property (p_hold) else $error("result moved while idle");

  // Main scenarios
  c_blocked: cover property (eg_valid && eg_mask == 8'h00);
  c_tagged:  cover property (in_valid && in_tagged);
  c_mixed:   cover property (eg_valid && eg_strip != eg_mask);
endmodule

bind pvi_top pvi_top_chk u_chk (
  .mclk(mclk), .rstn(rstn), .in_valid(in_valid), .in_port(in_port),
  .in_tagged(in_tagged), .in_vid(in_vid), .eg_valid(eg_valid),
  .eg_mask(eg_mask), .eg_strip(eg_strip), .eg_vid(eg_vid)
);

// >>> pvi_station.sv
// End station model: sends one frame descriptor per request.
// Assumes requests arrive by the bench right after a rising edge.
`timescale 1ns/10ps
module pvi_station (
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rstn,
  // Request from bench
  input  wire logic                     send,
  input  wire logic [pvi_pkg::PW-1:0]   s_port,
  input  wire logic                     s_tagged,
  input  wire logic [pvi_pkg::VIDW-1:0] s_vid,
  // Descriptor to the switch
  output logic                          in_valid,
  output logic      [pvi_pkg::PW-1:0]   in_port,
  output logic                          in_tagged,
  output logic      [pvi_pkg::VIDW-1:0] in_vid
);
  // Idle fields toggle so stale values never look valid
  always_ff @(posedge mclk) begin
    in_valid <= rstn & send;
    if (!rstn) begin
      in_port   <= '0;
      in_tagged <= 1'b0;
      in_vid    <= '0;
    end else if (send) begin
      in_port   <= s_port;
      in_tagged <= s_tagged;
      in_vid    <= s_vid;
    end else begin
      in_port   <= ~in_port;
      in_tagged <= ~in_tagged;
      in_vid    <= ~in_vid;
    end
  end
endmodule

// >>> tb.sv
// Self-checking bench for pvi_top: APB setup, then frames.
// Assumes the one-wait-state APB slave and one-cycle egress answer.
`timescale 1ns/10ps
module tb;
  import pvi_pkg::*;
  // Row of an ordinary frame case
  typedef struct packed {
    logic [2:0] p; logic t; logic [11:0] v;
    logic [7:0] m; logic [7:0] s; logic [11:0] ev;
  } pvi_row_t;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic [11:0] paddr = '0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        send = 1'b0;
  logic [2:0]  s_port = '0;
  logic        s_tagged = 1'b0;
  logic [11:0] s_vid = '0;
  logic        in_valid, in_tagged, eg_valid;
  logic [2:0]  in_port;
  logic [11:0] in_vid, eg_vid;
  logic [7:0]  eg_mask, eg_strip;
  logic [31:0] rd;
  logic        er;
  int          failures = 0;
  int          checks_done = 0;
  int          cyc = 0;
  // Ports 0,1 isolated; VLAN 2 = ports 0..3, port 3 tagged
  pvi_row_t rows [6] = '{
    '{3'h0, 1'b0, 12'hABC, 8'h0C, 8'h04, 12'h002},  // isolated source
    '{3'h1, 1'b0, 12'h000, 8'h0C, 8'h04, 12'h002},  // isolated source
    '{3'h2, 1'b0, 12'h000, 8'h0B, 8'h03, 12'h002},  // promiscuous source
    '{3'h3, 1'b1, 12'h002, 8'h07, 8'h07, 12'h002},  // tagged ingress
    '{3'h4, 1'b1, 12'h002, 8'h00, 8'h00, 12'h002},  // not a VLAN member
    '{3'h1, 1'b1, 12'h014, 8'h00, 8'h00, 12'h014}}; // VLAN with no table entry

  always #5 mclk = ~mclk;

  pvi_top DUT (.mclk(mclk), .rstn(rstn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .in_valid(in_valid), .in_port(in_port),
    .in_tagged(in_tagged), .in_vid(in_vid), .eg_valid(eg_valid),
    .eg_mask(eg_mask), .eg_strip(eg_strip), .eg_vid(eg_vid));

  pvi_station u_sta (.mclk(mclk), .rstn(rstn), .send(send), .s_port(s_port),
    .s_tagged(s_tagged), .s_vid(s_vid), .in_valid(in_valid), .in_port(in_port),
    .in_tagged(in_tagged), .in_vid(in_vid));

  // Verdict and end of run
  task automatic complete_run;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One comparison
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // APB transfer; waits for pready with a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      $display("wrong value at %0t: no APB answer", $time);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  // One frame through the station, then compare the decision
  task automatic frame(input pvi_row_t r);
    int n;
    n = 0;
    s_port <= r.p;
    s_tagged <= r.t;
    s_vid <= r.v;
    send <= 1'b1;
    @(posedge mclk);
    send <= 1'b0;
    do begin
      @(posedge mclk);
      n++;
    end while (eg_valid !== 1'b1 && n < 8);
    chk(32'(eg_valid), 32'h1);
    chk(32'(eg_mask), 32'(r.m));
    chk(32'(eg_strip), 32'(r.s));
    chk(32'(eg_vid), 32'(r.ev));
  endtask

  // Hang guard, far above the expected run length
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      $display("wrong value at %0t: run timed out", $time);
      complete_run();
    end
  end

  initial begin
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    apb(1'b0, OFS_ISOL, '0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h0C0, '0);
    chk(rd, 32'h0003FFFF);
    frame('{3'h7, 1'b0, 12'h005, 8'h7F, 8'h7F, 12'h001});
    // Configure VLAN 2, port default ids, isolation
    apb(1'b1, 12'h088, 32'h0000070F);
    apb(1'b1, 12'h040, 32'h2);
    apb(1'b1, 12'h044, 32'h2);
    apb(1'b1, 12'h048, 32'h2);
    apb(1'b1, OFS_ISOL, 32'h3);
    apb(1'b0, OFS_ISOL, '0);
    chk(rd, 32'h3);
    apb(1'b0, 12'h088, '0);
    chk(rd, 32'h0000070F);
    apb(1'b0, 12'h044, '0);
    chk(rd, 32'h2);
    foreach (rows[i]) frame(rows[i]);
    // Out-of-range private VLAN id
    apb(1'b1, OFS_PVCMD, 32'h109);
    apb(1'b0, OFS_STAT, '0);
    chk(rd, 32'h1);
    apb(1'b0, 12'h0E0, '0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, OFS_STAT, 32'h1);
    apb(1'b0, OFS_STAT, '0);
    chk(rd, 32'h0);
    // New entry is empty and staged
    apb(1'b1, OFS_PVCMD, 32'h102);
    apb(1'b0, 12'h0C4, '0);
    chk(rd, 32'h00010000);
    apb(1'b1, 12'h0C4, 32'h0F);
    apb(1'b1, OFS_PVCMD, 32'h201);
    frame('{3'h4, 1'b0, 12'h000, 8'hEF, 8'hEF, 12'h001});
    apb(1'b1, OFS_CTRL, 32'h1);
    frame('{3'h4, 1'b0, 12'h000, 8'h00, 8'h00, 12'h001});
    frame('{3'h0, 1'b0, 12'h000, 8'h0C, 8'h04, 12'h002});
    // Reset in mid-run brings every default back
    rstn <= 1'b0;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    apb(1'b0, OFS_ISOL, '0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h0C4, '0);
    chk(rd, 32'h0);
    frame('{3'h0, 1'b0, 12'h000, 8'hFE, 8'hFE, 12'h001});
    complete_run();
  end
endmodule
